// >>> hw/msice_export.sv
// configuration-space message-signalled-interrupt state and its export to the application
// assumes configuration reads and writes arrive synchronous to core_clk, one per cycle
//
// Operation
// RULE1 - export programmed message data, sixteen bits
// RULE2 - export captured bus and device number
// RULE3 - per-vector mask capable bit reads zero
// RULE4 - application supplies its own per-vector masking
// RULE5 - bit seven reports 64-bit address capability
// RULE6 - allocated vector code; reserved codes never stored
// RULE7 - bits three to one report requested vectors
// RULE8 - no message while enable bit clear; enable sampled in request cycle, so a same-cycle disabling write still sends
// RULE9 - whole control register presented on output
// RULE10 - exports update on clock edge after write
module msice_export
	import msice_pkg::*;
#(
	parameter logic       CAP64    = 1'b1,
	parameter logic [2:0] REQ_CODE = 3'h5
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        cfg_wr_en,
	input  wire logic        cfg_rd_en,
	input  wire logic [11:0] cfg_addr,
	input  wire logic [31:0] cfg_wr_data,
	input  wire logic [3:0]  cfg_wr_be,
	input  wire logic [12:0] cfg_req_busdev,
	input  wire logic        app_msi_req,
	input  wire logic [4:0]  app_msi_vector,
	output logic      [31:0] cfg_rd_data,
	output logic             cfg_rd_valid,
	output logic      [15:0] msi_payload_out,
	output logic      [12:0] bus_device_number_out,
	output logic      [15:0] msi_control_out,
	output logic             msi_send_req,
	output logic      [15:0] msi_send_data,
	output logic             msi_req_refused
);

	localparam logic [11:0] DATA_OFFSET = CAP64 ? MSICE_DATA64_OFFSET : MSICE_DATA32_OFFSET;

	// vectors granted by an allocation code, minus one, used as the low-bit mask
	function automatic logic [4:0] msice_vec_mask(input logic [2:0] code);
		logic [4:0] m;
		m = 5'h00;
		for (int i = 0; i < 5; i++) begin
			if (i < int'(code)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	logic        cap_hit;
	logic        data_hit;
	logic [15:0] ctrl_next;
	logic [31:0] rd_word;
	logic [4:0]  vec_mask;
	msice_req_e  req_state;

	assign cap_hit  = (cfg_addr == MSICE_CAP_OFFSET);
	assign data_hit = (cfg_addr == DATA_OFFSET);
	assign vec_mask = msice_vec_mask(msi_control_out[MSICE_MME_LSB +: 3]);

	msice_ctrl_merge #(
		.CAP64    (CAP64),
		.REQ_CODE (REQ_CODE)
	) u_merge (
		.wr_hit     (cfg_wr_en && cap_hit),
		.wr_byte_en (cfg_wr_be[MSICE_CTRL_BYTE]),
		.wr_val     (cfg_wr_data[MSICE_CTRL_LSB +: 16]),
		.cur_val    (msi_control_out),
		.next_val   (ctrl_next)
	);

	// control register, its read-only bits forced every cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			msi_control_out <= MSICE_CTRL_RESET | {7'h00, 1'b0, CAP64, 3'h0, REQ_CODE, 1'b0};
		end else begin
			msi_control_out <= ctrl_next; // RULE9 RULE10
		end
	end

	// message data, byte-wise writable
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			msi_payload_out <= MSICE_DATA_RESET;
		end else if (cfg_wr_en && data_hit) begin
			for (int b = 0; b < 2; b++) begin
				if (cfg_wr_be[b]) begin
					msi_payload_out[b*8 +: 8] <= cfg_wr_data[b*8 +: 8]; // RULE1
				end
			end
		end
	end

	// every configuration write carries the completer's bus and device number
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bus_device_number_out <= MSICE_BUSDEV_RESET;
		end else if (cfg_wr_en) begin
			bus_device_number_out <= cfg_req_busdev; // RULE2
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		if (cap_hit) begin
			rd_word = {msi_control_out, MSICE_NEXT_PTR, MSICE_CAP_ID};
		end else if (data_hit) begin
			rd_word = {16'h0000, msi_payload_out};
		end
	end

	// a read in the same cycle as a write returns the value before the write
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_rd_valid <= 1'b0;
			cfg_rd_data  <= 32'h0000_0000;
		end else begin
			cfg_rd_valid <= cfg_rd_en;
			if (cfg_rd_en) begin
				cfg_rd_data <= rd_word;
			end
		end
	end

	// no per-vector masking here: a vector outside the allocation is refused outright
	always_comb begin
		req_state = MSICE_IDLE;
		if (app_msi_req) begin
			if (msi_control_out[MSICE_EN_BIT] && ((app_msi_vector & ~vec_mask) == 5'h00)) begin
				req_state = MSICE_SEND; // RULE8
			end else begin
				req_state = MSICE_REFUSE; // RULE4
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			msi_send_req    <= 1'b0;
			msi_req_refused <= 1'b0;
			msi_send_data   <= 16'h0000;
		end else begin
			msi_send_req    <= 1'b0;
			msi_req_refused <= 1'b0;
			case (req_state)
				MSICE_SEND: begin
					msi_send_req  <= 1'b1; // RULE8
					msi_send_data <= (msi_payload_out & ~{11'h000, vec_mask})
						| {11'h000, app_msi_vector & vec_mask};
				end
				MSICE_REFUSE: begin
					msi_req_refused <= 1'b1;
				end
				default: begin
					msi_send_req <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_mask_cap_zero: assert property (msi_control_out[MSICE_MASKCAP_BIT] == 1'b0) // RULE3
		else $error("mask capable bit not zero");
	a_cap64_bit: assert property (msi_control_out[MSICE_CAP64_BIT] == CAP64) // RULE5
		else $error("64-bit capable bit wrong");
	a_mme_legal: assert property (msi_control_out[MSICE_MME_LSB +: 3] <= MSICE_CODE_MAX) // RULE6
		else $error("reserved allocation code stored");
	a_mme_reserved_kept: assert property (cfg_wr_en && cap_hit && cfg_wr_be[MSICE_CTRL_BYTE] // RULE6
		&& cfg_wr_data[MSICE_CTRL_LSB + MSICE_MME_LSB +: 3] > MSICE_CODE_MAX
		|=> $stable(msi_control_out[MSICE_MME_LSB +: 3]))
		else $error("reserved allocation code changed field");
	a_mmc_fixed: assert property (msi_control_out[MSICE_MMC_LSB +: 3] == REQ_CODE) // RULE7
		else $error("requested vector field wrong");
	a_no_send_disabled: assert property (!msi_control_out[MSICE_EN_BIT] && !app_msi_req ##1 app_msi_req // RULE8
		&& !msi_control_out[MSICE_EN_BIT] |=> !msi_send_req && msi_req_refused)
		else $error("message sent while disabled");
	a_send_cause: assert property (msi_send_req |-> $past(msi_control_out[MSICE_EN_BIT]) && $past(app_msi_req)) // RULE8
		else $error("send without enabled request");
	a_ctrl_export: assert property (cfg_wr_en && cap_hit && cfg_wr_be[MSICE_CTRL_BYTE] // RULE9 RULE10
		|=> msi_control_out[MSICE_EN_BIT] == $past(cfg_wr_data[MSICE_CTRL_LSB]))
		else $error("enable bit not exported after write");
	a_payload_export: assert property (cfg_wr_en && data_hit && cfg_wr_be[1:0] == 2'h3 // RULE1
		|=> msi_payload_out == $past(cfg_wr_data[15:0]))
		else $error("message data not exported");
	a_busdev_capture: assert property (cfg_wr_en |=> bus_device_number_out == $past(cfg_req_busdev)) // RULE2
		else $error("bus and device number not captured");
	a_read_answer: assert property (cfg_rd_en |=> cfg_rd_valid ##1 (cfg_rd_valid == $past(cfg_rd_en)))
		else $error("read answer latency wrong");

	c_send: cover property (app_msi_req ##1 msi_send_req);
	c_refused: cover property (msi_req_refused);
	c_enable_set: cover property (!msi_control_out[MSICE_EN_BIT] ##1 msi_control_out[MSICE_EN_BIT]);
	c_reserved_write: cover property (cfg_wr_en && cap_hit && cfg_wr_data[22:20] == 3'h7);

endmodule

// >>> hw/msice_pkg.sv
// package for the exported message-signalled-interrupt configuration block
// assumes a single core clock and dword-aligned configuration byte addresses
package msice_pkg;

	localparam logic [11:0] MSICE_CAP_OFFSET     = 12'h050;
	localparam logic [11:0] MSICE_DATA64_OFFSET  = 12'h05c;
	localparam logic [11:0] MSICE_DATA32_OFFSET  = 12'h058;

	localparam int          MSICE_CTRL_LSB       = 16;
	localparam int          MSICE_CTRL_BYTE      = 2;
	localparam int          MSICE_EN_BIT         = 0;
	localparam int          MSICE_MMC_LSB        = 1;
	localparam int          MSICE_MME_LSB        = 4;
	localparam int          MSICE_CAP64_BIT      = 7;
	localparam int          MSICE_MASKCAP_BIT    = 8;

	localparam logic [2:0]  MSICE_CODE_MAX       = 3'h5;
	localparam logic [15:0] MSICE_CTRL_RESET     = 16'h0000;
	localparam logic [15:0] MSICE_DATA_RESET     = 16'h0000;
	localparam logic [12:0] MSICE_BUSDEV_RESET   = 13'h0000;
	localparam logic [7:0]  MSICE_CAP_ID         = 8'h05;
	localparam logic [7:0]  MSICE_NEXT_PTR       = 8'h00;
	localparam int          MSICE_READ_LATENCY   = 1;

	typedef enum logic [1:0] {
		MSICE_IDLE,
		MSICE_SEND,
		MSICE_REFUSE
	} msice_req_e;

endpackage

// >>> hw/msice_ctrl_merge.sv
// next value of the 16-bit message control register from a configuration write
// assumes the caller qualifies wr_hit and presents the current register value
module msice_ctrl_merge
	import msice_pkg::*;
#(
	parameter logic       CAP64    = 1'b1,
	parameter logic [2:0] REQ_CODE = 3'h5
) (
	input  wire logic        wr_hit,
	input  wire logic        wr_byte_en,
	input  wire logic [15:0] wr_val,
	input  wire logic [15:0] cur_val,
	output logic      [15:0] next_val
);

	logic       en_bit;
	logic [2:0] mme_code;

	always_comb begin
		en_bit   = cur_val[MSICE_EN_BIT];
		mme_code = cur_val[MSICE_MME_LSB +: 3];
		if (wr_hit && wr_byte_en) begin
			en_bit = wr_val[MSICE_EN_BIT]; // RULE8
			// reserved allocation codes are dropped so software never sees them
			if (wr_val[MSICE_MME_LSB +: 3] <= MSICE_CODE_MAX) begin
				mme_code = wr_val[MSICE_MME_LSB +: 3]; // RULE6
			end
		end
		next_val                        = 16'h0000;
		next_val[MSICE_EN_BIT]          = en_bit;
		next_val[MSICE_MMC_LSB +: 3]    = REQ_CODE; // RULE7
		next_val[MSICE_MME_LSB +: 3]    = mme_code;
		next_val[MSICE_CAP64_BIT]       = CAP64; // RULE5
		next_val[MSICE_MASKCAP_BIT]     = 1'b0; // RULE3
	end

endmodule

// >>> test/msice_app_model.sv
// application-side model: raises interrupt requests from the exported state
// assumes core_clk domain; the bench commands one request per go pulse
module msice_app_model
	import msice_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        go,
	input  wire logic        rude,
	input  wire logic [4:0]  vec,
	input  wire logic [31:0] mask_reg,
	input  wire logic [15:0] msi_control_out,
	output logic             app_msi_req,
	output logic      [4:0]  app_msi_vector
);
	timeunit 1ns;
	timeprecision 1ps;
	// own mask register stands in for the missing per-vector masking
	always_ff @(posedge core_clk) begin
		app_msi_req <= rst_n & go & ~mask_reg[vec] & (msi_control_out[MSICE_EN_BIT] | rude);
	end
	// vector lines toggle when idle so a stale value never passes for a real one
	always_ff @(posedge core_clk) begin
		app_msi_vector <= go ? vec : ~app_msi_vector;
	end
endmodule

// >>> test/msice_export_tb.sv
// self-checking bench for the exported interrupt configuration block
// assumes default parameters: 64-bit capable, requested code 5
module msice_export_tb
	import msice_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst_n, cfg_wr_en, cfg_rd_en, go, rude, cfg_rd_valid, msi_send_req, msi_req_refused;
	logic [11:0] cfg_addr;
	logic [31:0] cfg_wr_data, cfg_rd_data;
	logic [3:0] cfg_wr_be;
	logic [12:0] busdev, bus_device_number_out;
	logic [4:0] vec, app_msi_vector;
	logic [15:0] msi_payload_out, msi_control_out, msi_send_data, pay;
	logic [2:0] code;
	logic [4:0] pick;
	logic app_msi_req;
	int n_fail, total_checks;
	msice_export u_msice_export (.core_clk(core_clk), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
		.cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_wr_be(cfg_wr_be), .cfg_req_busdev(busdev),
		.app_msi_req(app_msi_req), .app_msi_vector(app_msi_vector), .cfg_rd_data(cfg_rd_data),
		.cfg_rd_valid(cfg_rd_valid), .msi_payload_out(msi_payload_out), .bus_device_number_out(bus_device_number_out),
		.msi_control_out(msi_control_out), .msi_send_req(msi_send_req), .msi_send_data(msi_send_data),
		.msi_req_refused(msi_req_refused));
	msice_app_model u_msice_app_model (.core_clk(core_clk), .rst_n(rst_n), .go(go), .rude(rude), .vec(vec),
		.mask_reg(32'h0), .msi_control_out(msi_control_out), .app_msi_req(app_msi_req),
		.app_msi_vector(app_msi_vector));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge core_clk);
		cfg_wr_en <= 1'b1;
		cfg_addr <= a;
		cfg_wr_data <= d;
		cfg_wr_be <= be;
		busdev <= 13'($urandom);
		@(posedge core_clk);
		cfg_wr_en <= 1'b0;
		#1;
		chk("busdev", {19'h0, bus_device_number_out}, {19'h0, busdev});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		cfg_rd_en <= 1'b1;
		cfg_addr <= a;
		@(posedge core_clk);
		cfg_rd_en <= 1'b0;
		#1;
		chk("rd_valid", {31'h0, cfg_rd_valid}, 32'h1);
		chk("rd_data", cfg_rd_data, exp);
	endtask
	// vector fits when no bit sits at or above the allocated code
	function automatic logic fits(input logic [4:0] v, input logic [2:0] c);
		return (v >> c) == 5'h0;
	endfunction
	// message data: payload with its low allocated bits replaced by the vector
	function automatic logic [15:0] exp_data(input logic [15:0] p, input logic [4:0] v, input logic [2:0] c);
		logic [15:0] low;
		low = (16'h1 << c) - 16'h1;
		return (p & ~low) | ({11'h000, v} & low);
	endfunction
	task automatic req(input logic [4:0] v, input logic r, input logic ok);
		@(posedge core_clk);
		go <= 1'b1;
		vec <= v;
		rude <= r;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("send", {31'h0, msi_send_req}, {31'h0, ok});
		chk("refuse", {31'h0, msi_req_refused}, {31'h0, ~ok});
		if (ok)
			chk("send_data", {16'h0, msi_send_data}, {16'h0, exp_data(pay, v, code)});
	endtask
	initial begin
		{rst_n, cfg_wr_en, cfg_rd_en, go, rude, cfg_addr, cfg_wr_data, cfg_wr_be, busdev, vec} = '0;
		n_fail = $urandom(32'hd9879dd0);
		n_fail = 0;
		total_checks = 0;
		code = 3'h0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		chk("ctrl_reset", {16'h0, msi_control_out}, 32'h0000_008a);
		pay = 16'($urandom);
		wr(12'h05c, {16'h0, pay}, 4'h3);
		chk("payload", {16'h0, msi_payload_out}, {16'h0, pay});
		rd(MSICE_DATA64_OFFSET, {16'h0, pay});
		for (int c = 0; c < 8; c++) begin
			wr(12'h050, {7'h0, 1'b1, 1'b0, 3'(c), 3'h0, 1'b1, 16'h0}, 4'hc);
			if (c <= 5)
				code = 3'(c);
			chk("ctrl", {16'h0, msi_control_out}, {16'h0, 7'h0, 1'b0, 1'b1, code, 3'h5, 1'b1});
			rd(12'h050, {7'h0, 1'b0, 1'b1, code, 3'h5, 1'b1, 16'h0005});
			for (int j = 0; j < 4; j++) begin
				pick = j ? 5'($urandom) : 5'((6'h1 << code) - 6'h1);
				req(pick, 1'b0, fits(pick, code));
			end
		end
		wr(12'h050, 32'h0, 4'hc);
		req(5'h0, 1'b1, 1'b0);
		rd(12'h0f0, 32'h0);
		results();
	end
	initial begin
		#200000;
		n_fail++;
		results();
	end
endmodule
